// ### hw/ptid_defines.svh
`ifndef PTID_DEFINES_SVH
`define PTID_DEFINES_SVH

// register byte offsets on the AHB-Lite slave
`define PTID_OFS_WIN_BASE 12'h1A4
`define PTID_OFS_WIN_BOUND 12'h1A8
`define PTID_OFS_ADDR_OFFSET 12'h1AC
`define PTID_OFS_CONTROL 12'h1B4
`define PTID_OFS_STATUS 12'h1F0

// control register field positions
`define PTID_CTL_ENABLE 31
`define PTID_CTL_POSTED 30
`define PTID_CTL_WIDTH_HI 23
`define PTID_CTL_WIDTH_LO 22
`define PTID_CTL_SPACE_HI 18
`define PTID_CTL_SPACE_LO 16
`define PTID_CTL_PROGRAM 14
`define PTID_CTL_SUPER 12
`define PTID_CTL_BLOCK 8
`define PTID_CTL_PCI_IO 0

// implemented control bits and reset value (max width 32-bit)
`define PTID_CTL_MASK 32'hC0C7_5101
`define PTID_CTL_RESET 32'h0080_0000

// base and offset hold bits 31..12 only
`define PTID_WIN_MASK 32'hFFFF_F000
`define PTID_WIN_RESET 32'h0000_0000
`define PTID_XLATE_LSB 12

// default bound granularity in address bits (4 KB)
`define PTID_BOUND_LSB 12

// AHB encodings used by the slave
`define PTID_HSIZE_WORD 3'h2
`define PTID_HRESP_OKAY 1'h0

`endif

// ### hw/ptid_pkg.sv
package ptid_pkg;

  typedef enum logic [2:0] {
    PTID_SPACE_A16 = 3'b000,
    PTID_SPACE_A24 = 3'b001,
    PTID_SPACE_A32 = 3'b010,
    PTID_SPACE_RSV3 = 3'b011,
    PTID_SPACE_RSV4 = 3'b100,
    PTID_SPACE_CRCSR = 3'b101,
    PTID_SPACE_USER1 = 3'b110,
    PTID_SPACE_USER2 = 3'b111
  } ptid_space_type;

  typedef enum logic [1:0] {
    PTID_WIDTH_8 = 2'b00,
    PTID_WIDTH_16 = 2'b01,
    PTID_WIDTH_32 = 2'b10,
    PTID_WIDTH_64 = 2'b11
  } ptid_width_type;

  // one PCI transaction address offered to the image
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic io_space;
    logic write;
  } ptid_pci_req_type;

  // decode result handed to the VMEbus master side
  typedef struct packed {
    logic valid;
    logic hit;
    logic [31:0] addr;
    ptid_space_type space;
    ptid_width_type width;
    logic am_program;
    logic am_supervisor;
    logic block;
    logic mblt;
    logic posted;
  } ptid_vme_req_type;

endpackage

// ### hw/ptid_top.sv
// How it works
// - base is the lowest decoded address
// - nonzero bound: hit needs address below bound
// - zero bound: no upper limit above base
// - image 4 bound compares at 4 KB
// - other images bound compares at 64 KB
// - VMEbus bits 31..12 are address plus offset
// - block select only for A24/A32, width up to 32
// - A24/A32 with 64-bit width allows multiplexed blocks
// - PCI I/O space forces coupled, ignores posted enable
// - posted write enable, resets to zero
// - max width codes 8/16/32/64, resets to 32
// - address space codes, 011 and 100 reserved
// - program select picks program or data modifier
// - privilege select picks supervisor or user modifier
// - block select forbids or allows block transfers
// - PCI space select picks memory or I/O
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "ptid_defines.svh"
module ptid_top #(
  parameter int unsigned BOUND_LSB = `PTID_BOUND_LSB
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire ptid_pkg::ptid_pci_req_type pci_req,
  output ptid_pkg::ptid_vme_req_type vme_req
);
  import ptid_pkg::*;

  // bound keeps only the bits at or above its granularity
  localparam logic [31:0] BOUND_MASK = 32'hFFFF_FFFF << BOUND_LSB;

  // register storage, named after the image each one serves
  logic [31:0] image4_window_base;
  logic [31:0] image4_window_bound;
  logic [31:0] image4_address_offset;
  logic [31:0] image5_control;
  logic [15:0] hit_count;
  logic [15:0] miss_count;
  logic [31:0] status_word;

  // next values, also used by the read mux so a read right after a write sees it
  logic [31:0] next_window_base;
  logic [31:0] next_window_bound;
  logic [31:0] next_address_offset;
  logic [31:0] next_image_control;

  // AHB data phase bookkeeping
  logic wr_pending;
  logic [11:0] wr_addr;
  logic addr_phase;
  logic rd_take;
  logic wr_take;
  logic reg_page;
  logic [31:0] next_hrdata;

  // write selects, one per register, live in the data phase
  logic wr_base_sel;
  logic wr_bound_sel;
  logic wr_offset_sel;
  logic wr_control_sel;

  // control fields
  logic image_enable;
  logic posted_write_enable;
  ptid_width_type max_width_select;
  ptid_space_type address_space_select;
  logic program_data_select;
  logic privilege_select;
  logic block_transfer_select;
  logic pci_space_select;

  // decode terms
  logic space_is_a24_a32;
  logic space_legal;
  logic above_base;
  logic below_bound;
  logic window_hit;
  logic [19:0] xlate_high;

  // the registers sit in the lowest 4 KB page; other pages read zero
  assign reg_page = (haddr[31:12] == 20'h00000);
  assign addr_phase = hsel && hready && htrans[1];
  // only whole-word transfers change state; other sizes are taken but ignored
  assign wr_take = addr_phase && hwrite && (hsize == `PTID_HSIZE_WORD);
  assign rd_take = addr_phase && !hwrite;

  // capture the address of a write for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= 12'h000;
    end else if (hready) begin
      wr_pending <= wr_take && reg_page;
      wr_addr <= haddr[11:0];
    end
  end

  // one select per register keeps the data phase decode flat
  assign wr_base_sel = wr_pending && (wr_addr == `PTID_OFS_WIN_BASE);
  assign wr_bound_sel = wr_pending && (wr_addr == `PTID_OFS_WIN_BOUND);
  assign wr_offset_sel = wr_pending && (wr_addr == `PTID_OFS_ADDR_OFFSET);
  assign wr_control_sel = wr_pending && (wr_addr == `PTID_OFS_CONTROL);

  // base write: the low bits are reserved and never stored
  always_comb begin
    next_window_base = image4_window_base;
    if (wr_base_sel) begin
      next_window_base = hwdata & `PTID_WIN_MASK;
    end
  end

  // bound write: bits under the granularity are dropped at the source
  always_comb begin
    next_window_bound = image4_window_bound;
    if (wr_bound_sel) begin
      next_window_bound = hwdata & `PTID_WIN_MASK & BOUND_MASK;
    end
  end

  // offset write: only the translated bits are kept
  always_comb begin
    next_address_offset = image4_address_offset;
    if (wr_offset_sel) begin
      next_address_offset = hwdata & `PTID_WIN_MASK;
    end
  end

  // control write: unimplemented bits are masked so they read zero
  always_comb begin
    next_image_control = image5_control;
    if (wr_control_sel) begin
      next_image_control = hwdata & `PTID_CTL_MASK;
    end
  end

  // base comes up cleared; the disabled enable keeps the image closed anyway
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      image4_window_base <= `PTID_WIN_RESET;
    end else begin
      image4_window_base <= next_window_base;
    end
  end

  // bound comes up cleared, which reads as no upper limit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      image4_window_bound <= `PTID_WIN_RESET;
    end else begin
      image4_window_bound <= next_window_bound;
    end
  end

  // offset comes up cleared, so translation starts as identity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      image4_address_offset <= `PTID_WIN_RESET;
    end else begin
      image4_address_offset <= next_address_offset;
    end
  end

  // control register: enable and posted clear, width starts at 32-bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      image5_control <= `PTID_CTL_RESET;
    end else begin
      image5_control <= next_image_control;
    end
  end

  // field extraction
  assign image_enable = image5_control[`PTID_CTL_ENABLE];
  assign posted_write_enable = image5_control[`PTID_CTL_POSTED];
  assign max_width_select = ptid_width_type'(
    image5_control[`PTID_CTL_WIDTH_HI:`PTID_CTL_WIDTH_LO]);
  assign address_space_select = ptid_space_type'(
    image5_control[`PTID_CTL_SPACE_HI:`PTID_CTL_SPACE_LO]);
  assign program_data_select = image5_control[`PTID_CTL_PROGRAM];
  assign privilege_select = image5_control[`PTID_CTL_SUPER];
  assign block_transfer_select = image5_control[`PTID_CTL_BLOCK];
  assign pci_space_select = image5_control[`PTID_CTL_PCI_IO];

  // status packs both counters so one read gives a consistent pair
  assign status_word = {miss_count, hit_count};

  // read mux; unmapped addresses read zero
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (!reg_page) begin
      next_hrdata = 32'h0000_0000;
    end else if (haddr[11:0] == `PTID_OFS_WIN_BASE) begin
      next_hrdata = next_window_base;
    end else if (haddr[11:0] == `PTID_OFS_WIN_BOUND) begin
      next_hrdata = next_window_bound;
    end else if (haddr[11:0] == `PTID_OFS_ADDR_OFFSET) begin
      next_hrdata = next_address_offset;
    end else if (haddr[11:0] == `PTID_OFS_CONTROL) begin
      next_hrdata = next_image_control;
    end else if (haddr[11:0] == `PTID_OFS_STATUS) begin
      next_hrdata = status_word;
    end
  end

  // read data is loaded at the address phase so the slave never waits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= next_hrdata;
    end
  end

  // zero wait state: the slave never stretches a transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // every response is OKAY; refused accesses are simply ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= `PTID_HRESP_OKAY;
    end else begin
      hresp <= `PTID_HRESP_OKAY;
    end
  end

  // window compare; base and bound have zero low bits so whole-address
  // compares equal the compare at the register granularity
  assign above_base = pci_req.addr >= image4_window_base;
  assign below_bound = (image4_window_bound == 32'h0000_0000)
    || ((pci_req.addr & BOUND_MASK) < image4_window_bound);

  // reserved space codes leave the image closed rather than guess a cycle
  assign space_legal = (address_space_select != PTID_SPACE_RSV3)
    && (address_space_select != PTID_SPACE_RSV4);

  // only the two wide address spaces carry block modes
  assign space_is_a24_a32 = (address_space_select == PTID_SPACE_A24)
    || (address_space_select == PTID_SPACE_A32);

  // a request on the other PCI space is never claimed
  assign window_hit = image_enable
    && (pci_req.io_space == pci_space_select)
    && space_legal && above_base && below_bound;

  // two's complement add of the upper bits; carry out wraps
  assign xlate_high = pci_req.addr[31:`PTID_XLATE_LSB]
    + image4_address_offset[31:`PTID_XLATE_LSB];

  // request qualifiers, registered one cycle after the request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vme_req.valid <= 1'b0;
      vme_req.hit <= 1'b0;
    end else begin
      vme_req.valid <= pci_req.valid;
      // hit is qualified by valid so an idle cycle never claims
      vme_req.hit <= pci_req.valid && window_hit;
    end
  end

  // translated address; the page offset passes through untouched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vme_req.addr <= 32'h0000_0000;
    end else begin
      vme_req.addr <= {xlate_high, pci_req.addr[`PTID_XLATE_LSB-1:0]};
    end
  end

  // cycle attributes follow the control register as it stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vme_req.space <= PTID_SPACE_A16;
      vme_req.width <= PTID_WIDTH_8;
      vme_req.am_program <= 1'b0;
      vme_req.am_supervisor <= 1'b0;
    end else begin
      vme_req.space <= address_space_select;
      vme_req.width <= max_width_select;
      vme_req.am_program <= program_data_select;
      vme_req.am_supervisor <= privilege_select;
    end
  end

  // block modes; the select bit alone never forces a burst
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vme_req.block <= 1'b0;
      vme_req.mblt <= 1'b0;
    end else begin
      // block select only counts for A24/A32 at widths up to 32 bits
      vme_req.block <= block_transfer_select && space_is_a24_a32
        && (max_width_select != PTID_WIDTH_64);
      // 64-bit A24/A32 may burst multiplexed whatever the block select says
      vme_req.mblt <= space_is_a24_a32 && (max_width_select == PTID_WIDTH_64);
    end
  end

  // I/O space transactions are always coupled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vme_req.posted <= 1'b0;
    end else begin
      vme_req.posted <= pci_req.write && posted_write_enable
        && !pci_space_select;
    end
  end

  // hit counter saturates so software sees a ceiling, not a wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_count <= 16'h0000;
    end else if (pci_req.valid && window_hit
      && (hit_count != 16'hFFFF)) begin
      hit_count <= hit_count + 16'h0001;
    end
  end

  // miss counter, also saturating; idle cycles count as neither
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miss_count <= 16'h0000;
    end else if (pci_req.valid && !window_hit
      && (miss_count != 16'hFFFF)) begin
      miss_count <= miss_count + 16'h0001;
    end
  end

endmodule

// ### verification/ptid_asserts.sv
`timescale 1ns/1ps
module ptid_asserts #(
  parameter int unsigned BOUND_LSB = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire ptid_pkg::ptid_pci_req_type pci_req,
  input wire ptid_pkg::ptid_vme_req_type vme_req
);
  import ptid_pkg::*;
  // one clock domain, so reset masks every check once here
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ab;
  // block modes exist only in the two wide address spaces
  assign ab = vme_req.space inside {PTID_SPACE_A24, PTID_SPACE_A32};
  property p_follow;
    pci_req.valid |=> vme_req.valid && vme_req.addr[11:0] == $past(pci_req.addr[11:0]);
  endproperty
  a_follow: assert property (p_follow) else $error("low address bits lost");
  property p_idle;
    !pci_req.valid |=> !vme_req.valid && !vme_req.hit;
  endproperty
  a_idle: assert property (p_idle) else $error("claim without request");
  property p_rsv;
    vme_req.hit |-> !(vme_req.space inside {PTID_SPACE_RSV3, PTID_SPACE_RSV4});
  endproperty
  a_rsv: assert property (p_rsv) else $error("hit in reserved space");
  property p_block;
    vme_req.block |-> ab && vme_req.width != PTID_WIDTH_64;
  endproperty
  a_block: assert property (p_block) else $error("block mode out of place");
  property p_mblt;
    vme_req.valid |-> vme_req.mblt == (ab && vme_req.width == PTID_WIDTH_64);
  endproperty
  a_mblt: assert property (p_mblt) else $error("multiplexed block wrong");
  property p_coupled;
    pci_req.valid && pci_req.io_space |=> !(vme_req.hit && vme_req.posted);
  endproperty
  a_coupled: assert property (p_coupled) else $error("io transfer posted");
  property p_read;
    pci_req.valid && !pci_req.write |=> !vme_req.posted;
  endproperty
  a_read: assert property (p_read) else $error("read posted");
  property p_bus;
    hreadyout && !hresp;
  endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or not okay");
endmodule

bind ptid_top ptid_asserts #(.BOUND_LSB(BOUND_LSB)) u_ptid_asserts (
  .hclk(hclk),
  .hresetn(hresetn),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .pci_req(pci_req),
  .vme_req(vme_req)
);

// ### verification/ptid_pci_master.sv
`timescale 1ns/1ps
module ptid_pci_master (
  input wire logic hclk,
  output ptid_pkg::ptid_pci_req_type pci_req
);
  import ptid_pkg::*;
  initial pci_req = '0;
  // one address cycle; released lines then show the inverse, never a stale copy
  task automatic issue(input logic [31:0] a, input logic io, input logic wr);
    @(posedge hclk);
    pci_req <= '{1'b1, a, io, wr};
    @(posedge hclk);
    pci_req <= '{1'b0, ~a, ~io, ~wr};
  endtask
endmodule

// ### verification/pci_target_image_decode_test.sv
`timescale 1ns/1ps
`include "ptid_defines.svh"
module pci_target_image_decode_test;
  import ptid_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic ab;
  logic [31:0] hrdata;
  logic [31:0] ctl;
  ptid_pci_req_type pci_req;
  ptid_vme_req_type vme_req;
  int error_cnt = 0;
  int samples_checked = 0;
  always #50 hclk = ~hclk;
  ptid_top u_ptid_top (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .pci_req(pci_req),
    .vme_req(vme_req)
  );
  ptid_pci_master u_ptid_pci_master (
    .hclk(hclk),
    .pci_req(pci_req)
  );
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single transfer; each phase waits for hready
  task automatic xfer(input logic wr, input logic [11:0] a, inout logic [31:0] d);
    @(posedge hclk);
    haddr <= {20'h0, a};
    hwrite <= wr;
    hsize <= `PTID_HSIZE_WORD;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v = 32'h0;
    xfer(1'b0, a, v);
    chk("register", v, exp);
  endtask
  // a write request through the window, answer seen one cycle later
  task automatic dec(input logic [31:0] a, input logic io, input logic hit, input logic [31:0] va);
    u_ptid_pci_master.issue(a, io, 1'b1);
    #1;
    chk("valid", vme_req.valid, 32'h1);
    chk("hit", vme_req.hit, hit);
    if (hit) chk("vme address", vme_req.addr, va);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a hung handshake must not stall the run forever
  initial begin
    repeat (3000) @(posedge hclk);
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`PTID_OFS_WIN_BASE, 32'h0);
    rd(`PTID_OFS_WIN_BOUND, 32'h0);
    rd(`PTID_OFS_ADDR_OFFSET, 32'h0);
    rd(`PTID_OFS_CONTROL, 32'h0080_0000);
    rd(12'h1C0, 32'h0);
    dec(32'h0, 1'b0, 1'b0, 32'h0);
    wr(`PTID_OFS_WIN_BASE, 32'hFFFF_FFFF);
    rd(`PTID_OFS_WIN_BASE, 32'hFFFF_F000);
    wr(`PTID_OFS_ADDR_OFFSET, 32'h1000_0FFF);
    rd(`PTID_OFS_ADDR_OFFSET, 32'h1000_0000);
    wr(`PTID_OFS_WIN_BASE, 32'h0001_0000);
    wr(`PTID_OFS_WIN_BOUND, 32'h0002_3000);
    wr(`PTID_OFS_CONTROL, 32'h8002_0000);
    // edges of the window, bound 12 KB above a 64 KB line
    dec(32'h0000_FFFC, 1'b0, 1'b0, 32'h0);
    dec(32'h0001_0000, 1'b0, 1'b1, 32'h1001_0000);
    dec(32'h0002_2FFC, 1'b0, 1'b1, 32'h1002_2FFC);
    dec(32'h0002_3000, 1'b0, 1'b0, 32'h0);
    dec(32'h0001_0000, 1'b1, 1'b0, 32'h0);
    wr(`PTID_OFS_WIN_BOUND, 32'h0);
    dec(32'hFFFF_F004, 1'b0, 1'b1, 32'h0FFF_F004);
    // every space code, every width, both pci spaces
    for (int i = 0; i < 16; i++) begin
      ctl = 32'h8000_0000;
      ctl[`PTID_CTL_POSTED] = (i != 4);
      ctl[`PTID_CTL_WIDTH_HI:`PTID_CTL_WIDTH_LO] = {i[3], i[0]};
      ctl[`PTID_CTL_SPACE_HI:`PTID_CTL_SPACE_LO] = i[2:0];
      ctl[`PTID_CTL_PROGRAM] = i[0];
      ctl[`PTID_CTL_SUPER] = i[1];
      ctl[`PTID_CTL_BLOCK] = (i != 2);
      ctl[`PTID_CTL_PCI_IO] = i[3];
      ab = i[2:0] inside {3'd1, 3'd2};
      wr(`PTID_OFS_CONTROL, ctl);
      rd(`PTID_OFS_CONTROL, ctl);
      dec(32'h0001_0000, i[3], !(i[2:0] inside {3'd3, 3'd4}), 32'h1001_0000);
      chk("space", vme_req.space, i[2:0]);
      chk("width", vme_req.width, {i[3], i[0]});
      chk("program", vme_req.am_program, i[0]);
      chk("super", vme_req.am_supervisor, i[1]);
      chk("block", vme_req.block, ab && !(i[3] && i[0]) && i != 2);
      chk("mblt", vme_req.mblt, ab && i[3] && i[0]);
      chk("posted", vme_req.posted, i != 4 && !i[3]);
      // a read through the same window is never posted
      u_ptid_pci_master.issue(32'h0001_0000, i[3], 1'b0);
      #1;
      chk("read posted", vme_req.posted, 32'h0);
    end
    // 27 claimed and 12 refused requests in all
    rd(`PTID_OFS_STATUS, 32'h000C_001B);
    close_out;
  end
endmodule
